// file: shared/ctr_pkg.sv
// shared constants for the counter timebase and its processor end
package ctr_pkg;

    // ------------------------------------------------------------
    // register selection on the byte bus
    // ------------------------------------------------------------
    localparam logic [1:0] REG_LOW  = 2'h0;
    localparam logic [1:0] REG_HIGH = 2'h1;
    localparam logic [1:0] REG_MODE = 2'h2;

    // ------------------------------------------------------------
    // array_mode_register fields
    // ------------------------------------------------------------
    localparam int unsigned MD_IDLE_SUSPEND = 7;
    localparam int unsigned MD_WDOG_ENABLE  = 6;
    localparam int unsigned MD_OVF_FLAG     = 5;
    localparam int unsigned MD_TB_MSB       = 3;
    localparam int unsigned MD_TB_LSB       = 1;
    localparam int unsigned MD_IRQ_ENABLE   = 0;
    localparam logic [7:0]  MODE_RESET      = 8'h40;

    // ------------------------------------------------------------
    // timebase_select codes
    // ------------------------------------------------------------
    localparam logic [2:0] TB_DIV12   = 3'h0;
    localparam logic [2:0] TB_DIV4    = 3'h1;
    localparam logic [2:0] TB_TMR_OVF = 3'h2;
    localparam logic [2:0] TB_EXT_IN  = 3'h3;
    localparam logic [2:0] TB_SYSCLK  = 3'h4;
    localparam logic [2:0] TB_OSC_DIV = 3'h5;

    // ------------------------------------------------------------
    // divider counts
    // ------------------------------------------------------------
    localparam logic [3:0] DIV12_LAST = 4'hb;
    localparam logic [1:0] DIV4_LAST  = 2'h3;
    localparam logic [2:0] OSC_LAST   = 3'h7;

    // ------------------------------------------------------------
    // host command opcodes
    // ------------------------------------------------------------
    localparam logic [1:0] OP_RD   = 2'h0;
    localparam logic [1:0] OP_WR   = 2'h1;
    localparam logic [1:0] OP_RD16 = 2'h2;

endpackage

// file: shared/ctr_bus_if.sv
// byte-wide register bus between processor end and counter array
`timescale 1ns/1ps
interface ctr_bus_if;
    logic [1:0] addr;
    logic       rd;
    logic       wr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic       irq_req;
    logic       idle_mode;

    modport dev (
        input  addr,
        input  rd,
        input  wr,
        input  wdata,
        input  idle_mode,
        output rdata,
        output irq_req
    );

    modport host (
        output addr,
        output rd,
        output wr,
        output wdata,
        output idle_mode,
        input  rdata,
        input  irq_req
    );
endinterface

// file: src/ctr_sync.sv
// three-stage pin synchroniser with stable-level edge pulses
`timescale 1ns/1ps
module ctr_sync (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic pin,
    output logic      level,
    output logic      fall,
    output logic      rise
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic lvl_q;
    logic lvl_d;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // a change counts only once stages two and three agree
    always_comb begin
        lvl_d = (s2_q == s3_q) ? s3_q : lvl_q;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lvl_q <= 1'b0;
            fall  <= 1'b0;
            rise  <= 1'b0;
        end else begin
            lvl_q <= lvl_d;
            fall  <= lvl_q & ~lvl_d;
            rise  <= ~lvl_q & lvl_d;
        end
    end

    assign level = lvl_q;
endmodule

// file: src/ctr_dev.sv
// counter array timebase: 16-bit counter, snapshot, overflow, mode
//
// Overview of operation
// - 16-bit counter seen as two bytes
// - low-byte read snapshots high byte for next
// - software reads low byte before high byte
// - reads never disturb counting
// - three-bit selector picks six count sources
// - external input edges at most sysclk/4
// - divided oscillator resynchronised to system clock
// - wrap from all ones sets overflow flag
// - interrupt request only when enable set
// - flag stays set until software clears
// - processor needs global and array enables
// - suspend bit zero keeps counting in idle
// - count shared to three capture/compare modules
// - reset starts watchdog, restricts register writes
`timescale 1ns/1ps
module ctr_dev (
    input  wire logic              clk,
    input  wire logic              rst,
    ctr_bus_if.dev                 bus,
    input  wire logic              ext_count_in,
    input  wire logic              ext_osc_in,
    input  wire logic              timer_ovf,
    output logic [15:0]            count_value,
    output logic [2:0][15:0]       module_count,
    output logic                   wdog_active
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [15:0] cnt_q;
    logic [7:0]  snap_q;
    logic        snap_valid_q;
    logic [7:0]  rdata_q;
    logic [3:0]  div12_q;
    logic [1:0]  div4_q;
    logic [2:0]  osc_div_q;
    logic        idle_susp_q;
    logic        wdog_q;
    logic        ovf_q;
    logic [2:0]  tb_sel_q;
    logic        irq_en_q;

    logic        eci_fall;
    logic        osc_rise;
    logic        tick12;
    logic        tick4;
    logic        osc_tick;
    logic        tb_tick;
    logic        run;
    logic        inc;
    logic        ovf_set;
    logic        wr_low;
    logic        wr_high;
    logic        wr_mode;
    logic        rd_low;
    logic        rd_high;
    logic [7:0]  mode_view;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    assign wr_low  = bus.wr && bus.addr == ctr_pkg::REG_LOW;
    assign wr_high = bus.wr && bus.addr == ctr_pkg::REG_HIGH;
    assign wr_mode = bus.wr && bus.addr == ctr_pkg::REG_MODE;
    assign rd_low  = bus.rd && bus.addr == ctr_pkg::REG_LOW;
    assign rd_high = bus.rd && bus.addr == ctr_pkg::REG_HIGH;

    // ------------------------------------------------------------
    // timebase sources
    // ------------------------------------------------------------
    // both pins are asynchronous, so each crosses three flops
    ctr_sync u_eci (
        .clk   (clk),
        .rst   (rst),
        .pin   (ext_count_in),
        .level (),
        .fall  (eci_fall),
        .rise  ()
    );

    ctr_sync u_osc (
        .clk   (clk),
        .rst   (rst),
        .pin   (ext_osc_in),
        .level (),
        .fall  (),
        .rise  (osc_rise)
    );

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div12_q <= 4'h0;
        end else if (div12_q == ctr_pkg::DIV12_LAST) begin
            div12_q <= 4'h0;
        end else begin
            div12_q <= div12_q + 4'h1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div4_q <= 2'h0;
        end else begin
            div4_q <= div4_q + 2'h1;
        end
    end

    // divide after the crossing so every eighth edge is one pulse
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            osc_div_q <= 3'h0;
        end else if (osc_rise) begin
            osc_div_q <= osc_div_q + 3'h1;
        end
    end

    assign tick12   = div12_q == ctr_pkg::DIV12_LAST;
    assign tick4    = div4_q == ctr_pkg::DIV4_LAST;
    assign osc_tick = osc_rise && osc_div_q == ctr_pkg::OSC_LAST;

    always_comb begin
        case (tb_sel_q)
            ctr_pkg::TB_DIV12:   tb_tick = tick12;
            ctr_pkg::TB_DIV4:    tb_tick = tick4;
            ctr_pkg::TB_TMR_OVF: tb_tick = timer_ovf;
            ctr_pkg::TB_EXT_IN:  tb_tick = eci_fall;
            ctr_pkg::TB_SYSCLK:  tb_tick = 1'b1;
            ctr_pkg::TB_OSC_DIV: tb_tick = osc_tick;
            default:             tb_tick = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // counter
    // ------------------------------------------------------------
    assign run     = !(idle_susp_q && bus.idle_mode);
    assign inc     = tb_tick && run;
    // a byte write that beats the tick must not raise the flag
    assign ovf_set = inc && cnt_q == 16'hffff
                     && !((wr_low || wr_high) && !wdog_q);

    // byte writes win over a tick in the same cycle; reads never
    // touch this process
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 16'h0000;
        end else if (wr_low && !wdog_q) begin
            cnt_q[7:0] <= bus.wdata;
        end else if (wr_high && !wdog_q) begin
            cnt_q[15:8] <= bus.wdata;
        end else if (inc) begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end

    // ------------------------------------------------------------
    // snapshot of the high byte
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            snap_q       <= 8'h00;
            snap_valid_q <= 1'b0;
        end else if (rd_low) begin
            snap_q       <= cnt_q[15:8];
            snap_valid_q <= 1'b1;
        end else if (rd_high) begin
            snap_valid_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // mode register
    // ------------------------------------------------------------
    // while the watchdog runs, only the watchdog, flag and enable
    // bits accept writes, so its timebase cannot be altered
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            idle_susp_q <= ctr_pkg::MODE_RESET[ctr_pkg::MD_IDLE_SUSPEND];
            wdog_q      <= ctr_pkg::MODE_RESET[ctr_pkg::MD_WDOG_ENABLE];
            tb_sel_q    <= ctr_pkg::MODE_RESET[ctr_pkg::MD_TB_MSB:
                                               ctr_pkg::MD_TB_LSB];
            irq_en_q    <= ctr_pkg::MODE_RESET[ctr_pkg::MD_IRQ_ENABLE];
        end else if (wr_mode) begin
            wdog_q   <= bus.wdata[ctr_pkg::MD_WDOG_ENABLE];
            irq_en_q <= bus.wdata[ctr_pkg::MD_IRQ_ENABLE];
            if (!wdog_q) begin
                idle_susp_q <= bus.wdata[ctr_pkg::MD_IDLE_SUSPEND];
                tb_sel_q    <= bus.wdata[ctr_pkg::MD_TB_MSB:
                                         ctr_pkg::MD_TB_LSB];
            end
        end
    end

    // hardware set wins over a software clear in the same cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ovf_q <= ctr_pkg::MODE_RESET[ctr_pkg::MD_OVF_FLAG];
        end else if (ovf_set) begin
            ovf_q <= 1'b1;
        end else if (wr_mode) begin
            ovf_q <= bus.wdata[ctr_pkg::MD_OVF_FLAG];
        end
    end

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    always_comb begin
        mode_view = 8'h00;
        mode_view[ctr_pkg::MD_IDLE_SUSPEND] = idle_susp_q;
        mode_view[ctr_pkg::MD_WDOG_ENABLE]  = wdog_q;
        mode_view[ctr_pkg::MD_OVF_FLAG]     = ovf_q;
        mode_view[ctr_pkg::MD_TB_MSB:ctr_pkg::MD_TB_LSB] = tb_sel_q;
        mode_view[ctr_pkg::MD_IRQ_ENABLE]   = irq_en_q;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_q <= 8'h00;
        end else if (bus.rd) begin
            case (bus.addr)
                ctr_pkg::REG_LOW:  rdata_q <= cnt_q[7:0];
                ctr_pkg::REG_HIGH: rdata_q <= snap_valid_q ? snap_q
                                              : cnt_q[15:8];
                ctr_pkg::REG_MODE: rdata_q <= mode_view;
                default:           rdata_q <= 8'h00;
            endcase
        end
    end

    assign bus.rdata   = rdata_q;
    assign bus.irq_req = ovf_q && irq_en_q;

    // ------------------------------------------------------------
    // count fan-out to the capture/compare modules
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_mod
            assign module_count[g] = cnt_q;
        end
    endgenerate

    assign count_value = cnt_q;
    assign wdog_active = wdog_q;

endmodule

// file: src/ctr_host.sv
// processor end: issues register reads and writes, gates interrupt
`timescale 1ns/1ps
module ctr_host (
    input  wire logic        clk,
    input  wire logic        rst,
    ctr_bus_if.host          bus,
    input  wire logic        cmd_valid,
    input  wire logic [1:0]  cmd_op,
    input  wire logic [1:0]  cmd_addr,
    input  wire logic [7:0]  cmd_wdata,
    output logic             cmd_ready,
    output logic             rsp_valid,
    output logic [15:0]      rsp_data,
    input  wire logic        global_irq_enable,
    input  wire logic        array_irq_enable,
    input  wire logic        idle_req,
    output logic             irq_pending
);

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ISSUE1,
        ST_ISSUE2,
        ST_FIN
    } ctr_hst_e;

    ctr_hst_e    state_q;
    logic [1:0]  op_q;
    logic [1:0]  addr_q;
    logic [7:0]  wdata_q;
    logic [7:0]  lo_q;

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE:   if (cmd_valid) state_q <= ST_ISSUE1;
                ST_ISSUE1: state_q <= (op_q == ctr_pkg::OP_RD16)
                                      ? ST_ISSUE2 : ST_FIN;
                ST_ISSUE2: state_q <= ST_FIN;
                ST_FIN:    state_q <= ST_IDLE;
                default:   state_q <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            op_q    <= ctr_pkg::OP_RD;
            addr_q  <= ctr_pkg::REG_LOW;
            wdata_q <= 8'h00;
        end else if (state_q == ST_IDLE && cmd_valid) begin
            op_q    <= cmd_op;
            addr_q  <= cmd_addr;
            wdata_q <= cmd_wdata;
        end
    end

    assign cmd_ready = state_q == ST_IDLE;

    // ------------------------------------------------------------
    // bus drive
    // ------------------------------------------------------------
    // a wide read always takes the low byte first
    always_comb begin
        bus.rd    = 1'b0;
        bus.wr    = 1'b0;
        bus.addr  = addr_q;
        bus.wdata = wdata_q;
        case (state_q)
            ST_ISSUE1: begin
                bus.wr = op_q == ctr_pkg::OP_WR;
                bus.rd = op_q != ctr_pkg::OP_WR;
                if (op_q == ctr_pkg::OP_RD16) begin
                    bus.addr = ctr_pkg::REG_LOW;
                end
            end
            ST_ISSUE2: begin
                bus.rd   = 1'b1;
                bus.addr = ctr_pkg::REG_HIGH;
            end
            default: begin
                bus.rd = 1'b0;
            end
        endcase
    end

    assign bus.idle_mode = idle_req;

    // ------------------------------------------------------------
    // response
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lo_q      <= 8'h00;
            rsp_data  <= 16'h0000;
            rsp_valid <= 1'b0;
        end else begin
            rsp_valid <= state_q == ST_FIN;
            if (state_q == ST_ISSUE2) begin
                lo_q <= bus.rdata;
            end
            if (state_q == ST_FIN) begin
                if (op_q == ctr_pkg::OP_RD16) begin
                    rsp_data <= {bus.rdata, lo_q};
                end else if (op_q == ctr_pkg::OP_RD) begin
                    rsp_data <= {8'h00, bus.rdata};
                end
            end
        end
    end

    // the flag is never cleared here; software writes it back to 0
    assign irq_pending = bus.irq_req && global_irq_enable
                         && array_irq_enable;

endmodule

// file: tb/ctr_bus_checker.sv
// assertions on the register bus between processor end and counter
`timescale 1ns/1ps
module ctr_bus_checker (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic [1:0] addr,
    input wire logic       rd,
    input wire logic       wr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic       irq_req,
    input wire logic       idle_mode
);
    // ------------------------------------------------------------
    // bus sequences
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_mode_rd;
        rd && addr == ctr_pkg::REG_MODE;
    endsequence
    sequence s_irq_off;
        wr && addr == ctr_pkg::REG_MODE && !wdata[ctr_pkg::MD_IRQ_ENABLE];
    endsequence
    sequence s_en_wr;
        wr && addr == ctr_pkg::REG_MODE && wdata[ctr_pkg::MD_IRQ_ENABLE];
    endsequence
    sequence s_wd_off;
        wr && addr == ctr_pkg::REG_MODE && !wdata[ctr_pkg::MD_WDOG_ENABLE];
    endsequence

    a_strobe_excl: assert property (!(rd && wr))
        else $error("read and write strobes together");
    a_wr_single: assert property (wr |=> !wr)
        else $error("write strobe longer than one cycle");
    a_rdata_holds: assert property (!rd |=> $stable(rdata))
        else $error("read data changed without a read");
    a_unmapped_zero: assert property (rd && addr == 2'h3
        |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    a_mode_gap_zero: assert property (s_mode_rd |=> !rdata[4])
        else $error("unused mode bit reads one");
    a_irq_mask_off: assert property (s_irq_off |=> !irq_req)
        else $error("request with enable cleared");
    a_flag_set_wr: assert property (wr && addr == ctr_pkg::REG_MODE
        && wdata[ctr_pkg::MD_OVF_FLAG] && wdata[ctr_pkg::MD_IRQ_ENABLE]
        |=> irq_req)
        else $error("flag write with enable gave no request");
    a_irq_sticky: assert property (irq_req
        && !(wr && addr == ctr_pkg::REG_MODE) |=> irq_req)
        else $error("request dropped without software clear");
    a_irq_matches: assert property (s_mode_rd
        |=> (rdata[ctr_pkg::MD_OVF_FLAG] && rdata[ctr_pkg::MD_IRQ_ENABLE])
            == $past(irq_req))
        else $error("request disagrees with mode flag and enable");
    a_en_readback: assert property (s_en_wr ##[1:4] s_mode_rd
        |=> rdata[ctr_pkg::MD_IRQ_ENABLE])
        else $error("enable bit not read back");
    a_wdog_off: assert property (s_wd_off ##[1:4] s_mode_rd
        |=> !rdata[ctr_pkg::MD_WDOG_ENABLE])
        else $error("watchdog bit not cleared");
endmodule

// file: tb/programmable_counter_timebase_test.sv
// self-checking bench for the counter array and its processor end
`timescale 1ns/1ps
module programmable_counter_timebase_test;
    logic             clk;
    logic             rst;
    logic             cmd_valid;
    logic [1:0]       cmd_op;
    logic [1:0]       cmd_addr;
    logic [7:0]       cmd_wdata;
    logic             cmd_ready;
    logic             rsp_valid;
    logic [15:0]      rsp_data;
    logic             gie;
    logic             aie;
    logic             idle_req;
    logic             irq_pending;
    logic             ext_in;
    logic             osc_in;
    logic             tmr_ovf;
    logic [15:0]      count_value;
    logic [2:0][15:0] mod_cnt;
    logic             wdog_active;
    int               miscompares;
    int               checks;

    ctr_bus_if bus ();
    ctr_dev i_ctr_dev (.clk(clk), .rst(rst), .bus(bus), .ext_count_in(ext_in),
        .ext_osc_in(osc_in), .timer_ovf(tmr_ovf), .count_value(count_value),
        .module_count(mod_cnt), .wdog_active(wdog_active));
    ctr_host i_ctr_host (.clk(clk), .rst(rst), .bus(bus),
        .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
        .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data), .global_irq_enable(gie), .array_irq_enable(aie),
        .idle_req(idle_req), .irq_pending(irq_pending));
    ctr_bus_checker i_ctr_bus_checker (.clk(clk), .rst(rst),
        .addr(bus.addr), .rd(bus.rd), .wr(bus.wr), .wdata(bus.wdata),
        .rdata(bus.rdata), .irq_req(bus.irq_req), .idle_mode(bus.idle_mode));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic wrap_up;
        if (miscompares == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // valid held until an edge sees ready, then released
    task automatic cmd(input logic [1:0] op, input logic [1:0] a,
                       input logic [7:0] d);
        int n;
        n = 0;
        cmd_valid = 1'b1;
        cmd_op = op;
        cmd_addr = a;
        cmd_wdata = d;
        while (cmd_ready !== 1'b1 && n < 20) begin
            tick(1);
            n++;
        end
        if (cmd_ready !== 1'b1) begin
            miscompares++;
            wrap_up();
        end
        tick(1);
        cmd_valid = 1'b0;
        n = 0;
        while (rsp_valid !== 1'b1 && n < 20) begin
            tick(1);
            n++;
        end
        if (rsp_valid !== 1'b1) begin
            miscompares++;
            wrap_up();
        end
    endtask

    task automatic pulse;
        tmr_ovf = 1'b1;
        tick(1);
        tmr_ovf = 1'b0;
        tick(2);
    endtask

    task automatic rate(input logic [7:0] m, input int n,
                        input logic [15:0] exp);
        logic [15:0] c0;
        cmd(ctr_pkg::OP_WR, ctr_pkg::REG_MODE, m);
        tick(3);
        c0 = count_value;
        tick(n);
        chk(count_value - c0, exp);
        chk(mod_cnt[2], count_value);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_wdog;
        chk({15'h0, wdog_active}, 16'h0001);
        cmd(ctr_pkg::OP_RD, ctr_pkg::REG_MODE, 8'h00);
        chk(rsp_data, 16'h0040);
        cmd(ctr_pkg::OP_RD, 2'h3, 8'h00);
        chk(rsp_data, 16'h0000);
        // timebase bits are refused until the watchdog is off
        cmd(ctr_pkg::OP_WR, ctr_pkg::REG_MODE, 8'h04);
        cmd(ctr_pkg::OP_RD, ctr_pkg::REG_MODE, 8'h00);
        chk(rsp_data, 16'h0000);
        cmd(ctr_pkg::OP_WR, ctr_pkg::REG_MODE, 8'h04);
        cmd(ctr_pkg::OP_RD, ctr_pkg::REG_MODE, 8'h00);
        chk(rsp_data, 16'h0004);
        cmd(ctr_pkg::OP_WR, ctr_pkg::REG_LOW, 8'h33);
        cmd(ctr_pkg::OP_WR, ctr_pkg::REG_MODE, 8'h44);
        cmd(ctr_pkg::OP_WR, ctr_pkg::REG_LOW, 8'h55);
        cmd(ctr_pkg::OP_RD, ctr_pkg::REG_LOW, 8'h00);
        chk(rsp_data, 16'h0033);
        cmd(ctr_pkg::OP_WR, ctr_pkg::REG_MODE, 8'h04);
        chk({15'h0, wdog_active}, 16'h0000);
    endtask

    // timer overflow source keeps the count frozen between pulses
    task automatic t_snap;
        cmd(ctr_pkg::OP_WR, ctr_pkg::REG_HIGH, 8'h12);
        cmd(ctr_pkg::OP_WR, ctr_pkg::REG_LOW, 8'hff);
        cmd(ctr_pkg::OP_RD, ctr_pkg::REG_LOW, 8'h00);
        chk(rsp_data, 16'h00ff);
        pulse();
        cmd(ctr_pkg::OP_RD, ctr_pkg::REG_HIGH, 8'h00);
        chk(rsp_data, 16'h0012);
        cmd(ctr_pkg::OP_RD, ctr_pkg::REG_HIGH, 8'h00);
        chk(rsp_data, 16'h0013);
        cmd(ctr_pkg::OP_RD16, ctr_pkg::REG_LOW, 8'h00);
        chk(rsp_data, 16'h1300);
        pulse();
        cmd(ctr_pkg::OP_RD16, ctr_pkg::REG_LOW, 8'h00);
        chk(rsp_data, 16'h1301);
    endtask

    task automatic t_ovf;
        cmd(ctr_pkg::OP_WR, ctr_pkg::REG_MODE, 8'h05);
        cmd(ctr_pkg::OP_WR, ctr_pkg::REG_HIGH, 8'hff);
        cmd(ctr_pkg::OP_WR, ctr_pkg::REG_LOW, 8'hff);
        pulse();
        cmd(ctr_pkg::OP_RD16, ctr_pkg::REG_LOW, 8'h00);
        chk(rsp_data, 16'h0000);
        chk({15'h0, irq_pending}, 16'h0000);
        aie = 1'b1;
        tick(20);
        chk({15'h0, irq_pending}, 16'h0001);
        gie = 1'b0;
        tick(1);
        chk({15'h0, irq_pending}, 16'h0000);
        gie = 1'b1;
        cmd(ctr_pkg::OP_RD, ctr_pkg::REG_MODE, 8'h00);
        chk(rsp_data, 16'h0025);
        cmd(ctr_pkg::OP_WR, ctr_pkg::REG_MODE, 8'h24);
        chk({15'h0, irq_pending}, 16'h0000);
        cmd(ctr_pkg::OP_WR, ctr_pkg::REG_MODE, 8'h25);
        chk({15'h0, irq_pending}, 16'h0001);
        cmd(ctr_pkg::OP_WR, ctr_pkg::REG_MODE, 8'h05);
        chk({15'h0, irq_pending}, 16'h0000);
        cmd(ctr_pkg::OP_RD, ctr_pkg::REG_MODE, 8'h00);
        chk(rsp_data, 16'h0005);
    endtask

    // sixteen oscillator rises hold exactly two divide-by-eight ticks
    task automatic t_pins;
        logic [15:0] c0;
        cmd(ctr_pkg::OP_WR, ctr_pkg::REG_MODE, 8'h06);
        c0 = count_value;
        repeat (3) begin
            ext_in = 1'b0;
            tick(6);
            ext_in = 1'b1;
            tick(6);
        end
        tick(8);
        chk(count_value - c0, 16'h0003);
        cmd(ctr_pkg::OP_WR, ctr_pkg::REG_MODE, 8'h0a);
        c0 = count_value;
        repeat (16) begin
            osc_in = 1'b1;
            tick(4);
            osc_in = 1'b0;
            tick(4);
        end
        tick(10);
        chk(count_value - c0, 16'h0002);
    endtask

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    initial begin
        rst = 1'b1;
        cmd_valid = 1'b0;
        cmd_op = 2'h0;
        cmd_addr = 2'h0;
        cmd_wdata = 8'h00;
        gie = 1'b1;
        aie = 1'b0;
        idle_req = 1'b0;
        ext_in = 1'b1;
        osc_in = 1'b0;
        tmr_ovf = 1'b0;
        miscompares = 0;
        checks = 0;
        tick(3);
        rst = 1'b0;
        t_wdog();
        t_snap();
        t_ovf();
        rate(8'h00, 24, 16'h0002);
        rate(8'h02, 24, 16'h0006);
        rate(8'h08, 24, 16'h0018);
        rate(8'h0c, 24, 16'h0000);
        t_pins();
        idle_req = 1'b1;
        rate(8'h88, 20, 16'h0000);
        rate(8'h08, 20, 16'h0014);
        idle_req = 1'b0;
        wrap_up();
    end
endmodule
